// ===== ac_link_pkg.sv
// Constants and types for the AC-link status, modem slot and FIFO status block
package ac_link_pkg;
  localparam logic [7:0] CMD_OFS   = 8'h20;
  localparam logic [7:0] STAT_OFS  = 8'h24;
  localparam logic [7:0] MCTL_OFS  = 8'h28;
  localparam logic [7:0] MSTAT_OFS = 8'h2C;
  localparam logic [7:0] FIFO_OFS  = 8'h30;
  localparam logic [7:0] IST_OFS   = 8'h40;
  localparam logic [7:0] IMSK_OFS  = 8'h44;

  localparam int CMD_ENA_BIT  = 24;
  localparam int CMD_RD_BIT   = 7;
  localparam int MCTL_ENA_BIT = 20;
  localparam int RX_PURGE_BIT = 31;
  localparam int TX_PURGE_BIT = 30;

  // Slot 0 tag bit positions
  localparam int TAG_READY = 15;
  localparam int TAG_CMD   = 14;
  localparam int TAG_DATA  = 13;
  localparam int TAG_MODEM = 3;

  // Frame layout: 16-bit tag, then twelve 20-bit slots
  localparam logic [4:0] TAG_TOP   = 5'h0F;
  localparam logic [4:0] SLOT_TOP  = 5'h13;
  localparam logic [3:0] LAST_SLOT = 4'hC;

  localparam int IRQ_READ  = 0;
  localparam int IRQ_MODEM = 1;

  localparam logic [31:0] REG_RST = 32'h00000000;

  typedef struct packed {
    logic        ena;
    logic [15:0] wdata;
    logic        rd;
    logic [6:0]  idx;
  } cmd_t;

  typedef enum logic [1:0] {RD_IDLE, RD_SENT, RD_WAIT} rd_state_t;
endpackage

// ===== ac_link_status_modem_fifo.sv
// AC-link codec status, modem slot 12 and FIFO status block behind APB
`timescale 1ns/1ps
//
// Summary of operation
// RULE_01: Ready flag mirrors slot 0 codec-ready bit.
// RULE_02: Software waits for ready before codec use.
// RULE_03: Read request clears valid; returned data sets it.
// RULE_04: Keep the echoed 7-bit register index.
// RULE_05: Keep last valid 16-bit read value.
// RULE_06: Send request goes out next frame, self-clears.
// RULE_07: Software sets payload before send request.
// RULE_08: Payload field is serialised in slot 12.
// RULE_09: Capture valid incoming slot 12 status.
// RULE_10: Interrupt on each modem status update.
// RULE_11: Inbound purge empties receive FIFO, self-clears.
// RULE_12: Outbound purge empties transmit FIFO, self-clears.
// RULE_13: Report receive FIFO byte count.
// RULE_14: Command sent in slots 1, 2 next frame.
// RULE_15: Echo from slot 1, data from slot 2.

module ac_link_status_modem_fifo (
  input  wire logic        mclk,     // 20 MHz system clock
  input  wire logic        rst,      // Asynchronous reset, active high
  input  wire logic [11:0] paddr,    // APB address
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB enable
  input  wire logic        pwrite,   // APB write
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr,  // APB error, unmapped offset
  output logic             irq,      // Level interrupt
  input  wire logic        bitClk,   // Link bit clock from codec
  input  wire logic        sdataIn,  // Serial data from codec
  output logic             syncOut,  // Frame sync to codec
  output logic             sdataOut, // Serial data to codec
  input  wire logic [7:0]  rxLevel,  // Receive FIFO byte count
  input  wire logic [7:0]  txLevel,  // Transmit FIFO byte count
  output logic             rxPurge,  // Empty receive FIFO pulse
  output logic             txPurge   // Empty transmit FIFO pulse
);
  logic                  bclkMeta_reg, bclkSync_reg, bclkPrev_reg;
  logic                  sdinMeta_reg, sdinSync_reg;
  logic [3:0]            slot_reg, slotNext;
  logic [4:0]            bitIdx_reg, bitIdxNext;
  logic [19:0]           inShift_reg, inShiftNext;
  logic [15:0]           inTag_reg, inTagNext;
  logic                  sync_reg, syncNext;
  logic                  sdo_reg, sdoNext;
  ac_link_pkg::cmd_t     cmd_reg, cmdNext;
  ac_link_pkg::cmd_t     cmdSnap_reg, cmdSnapNext;
  logic                  sendCmd_reg, sendCmdNext;
  logic                  modemEna_reg, modemEnaNext;
  logic [19:0]           modemCtl_reg, modemCtlNext;
  logic [19:0]           modemSnap_reg, modemSnapNext;
  logic                  sendModem_reg, sendModemNext;
  logic [19:0]           modemStat_reg, modemStatNext;
  logic                  codecReady_reg, codecReadyNext;
  logic                  rdValid_reg, rdValidNext;
  logic [6:0]            echo_reg, echoNext;
  logic [6:0]            echoIdx_reg, echoIdxNext;
  logic [15:0]           readData_reg, readDataNext;
  ac_link_pkg::rd_state_t rdState_reg, rdStateNext;
  logic [1:0]            istat_reg, istatNext;
  logic [1:0]            imask_reg, imaskNext;
  logic                  irq_reg, irqNext;
  logic [31:0]           prdata_reg, prdataNext;
  logic                  pready_reg, preadyNext;
  logic                  pslverr_reg, pslverrNext;
  logic                  rxPurge_reg, rxPurgeNext;
  logic                  txPurge_reg, txPurgeNext;
  logic                  rise, fall, wrEn, frameStart;
  logic [19:0]           w, word;
  logic [1:0]            irqSet;
  function automatic logic hit(input logic [11:0] a, input logic [7:0] ofs);
    return a == {4'h0, ofs};
  endfunction
  function automatic logic mapped(input logic [11:0] a);
    return hit(a, ac_link_pkg::CMD_OFS) || hit(a, ac_link_pkg::STAT_OFS) ||
           hit(a, ac_link_pkg::MCTL_OFS) || hit(a, ac_link_pkg::MSTAT_OFS) ||
           hit(a, ac_link_pkg::FIFO_OFS) || hit(a, ac_link_pkg::IST_OFS) ||
           hit(a, ac_link_pkg::IMSK_OFS);
  endfunction
  assign rise       = bclkSync_reg && !bclkPrev_reg;
  assign fall       = !bclkSync_reg && bclkPrev_reg;
  assign w          = {inShift_reg[18:0], sdinSync_reg};
  assign wrEn       = psel && penable && pready_reg && pwrite;
  assign frameStart = rise && bitIdx_reg == 5'h00 && slot_reg == ac_link_pkg::LAST_SLOT;
  always_comb begin
    slotNext       = slot_reg;
    bitIdxNext     = bitIdx_reg;
    inShiftNext    = inShift_reg;
    inTagNext      = inTag_reg;
    syncNext       = sync_reg;
    sdoNext        = sdo_reg;
    cmdNext        = cmd_reg;
    cmdSnapNext    = cmdSnap_reg;
    sendCmdNext    = sendCmd_reg;
    modemEnaNext   = modemEna_reg;
    modemCtlNext   = modemCtl_reg;
    modemSnapNext  = modemSnap_reg;
    sendModemNext  = sendModem_reg;
    modemStatNext  = modemStat_reg;
    codecReadyNext = codecReady_reg;
    rdValidNext    = rdValid_reg;
    echoNext       = echo_reg;
    echoIdxNext    = echoIdx_reg;
    readDataNext   = readData_reg;
    rdStateNext    = rdState_reg;
    istatNext      = istat_reg;
    imaskNext      = imask_reg;
    irqSet         = 2'h0;
    word           = 20'h00000;
    // One wait state: the answer is ready on the second access cycle
    preadyNext     = psel && penable && !pready_reg;
    prdataNext     = prdata_reg;
    pslverrNext    = 1'b0;
    rxPurgeNext    = wrEn && hit(paddr, ac_link_pkg::FIFO_OFS)
                     && pwdata[ac_link_pkg::RX_PURGE_BIT]; // RULE_11
    txPurgeNext    = wrEn && hit(paddr, ac_link_pkg::FIFO_OFS)
                     && pwdata[ac_link_pkg::TX_PURGE_BIT]; // RULE_12
    if (preadyNext) begin
      pslverrNext = !mapped(paddr);
      prdataNext  = 32'h00000000;
      if (paddr[11:8] == 4'h0) begin
        case (paddr[7:0])
          ac_link_pkg::CMD_OFS:   prdataNext = {7'h00, cmd_reg};
          ac_link_pkg::STAT_OFS:  prdataNext = {7'h00, codecReady_reg, rdValid_reg,
                                                echoIdx_reg, readData_reg}; // RULE_01
          ac_link_pkg::MCTL_OFS:  prdataNext = {11'h000, modemEna_reg, modemCtl_reg};
          ac_link_pkg::MSTAT_OFS: prdataNext = {12'h000, modemStat_reg};
          // Purge bits are write-only and always read as zero
          ac_link_pkg::FIFO_OFS:  prdataNext = {16'h0000, rxLevel, txLevel}; // RULE_13
          ac_link_pkg::IST_OFS:   prdataNext = {30'h00000000, istat_reg};
          ac_link_pkg::IMSK_OFS:  prdataNext = {30'h00000000, imask_reg};
          default:                prdataNext = 32'h00000000;
        endcase
      end
    end
    // Outgoing side: advance on the bit clock rising edge
    if (rise) begin
      if (bitIdx_reg != 5'h00) begin
        bitIdxNext = bitIdx_reg - 5'h01;
      end else if (slot_reg == ac_link_pkg::LAST_SLOT) begin
        slotNext      = 4'h0;
        bitIdxNext    = ac_link_pkg::TAG_TOP;
        sendCmdNext   = cmd_reg.ena; // RULE_14
        cmdSnapNext   = cmd_reg;
        cmdNext.ena   = 1'b0;
        sendModemNext = modemEna_reg; // RULE_06
        modemSnapNext = modemCtl_reg;
        modemEnaNext  = 1'b0;
        if (rdState_reg == ac_link_pkg::RD_SENT) rdStateNext = ac_link_pkg::RD_WAIT;
        if (cmd_reg.ena && cmd_reg.rd) rdStateNext = ac_link_pkg::RD_SENT;
      end else begin
        slotNext   = slot_reg + 4'h1;
        bitIdxNext = ac_link_pkg::SLOT_TOP;
      end
      case (slotNext)
        4'h0: word = {4'h0, sendCmdNext || sendModemNext, sendCmdNext,
                      sendCmdNext && !cmdSnapNext.rd, 9'h000, sendModemNext, 3'h0};
        4'h1: if (sendCmdNext) word = {cmdSnapNext.rd, cmdSnapNext.idx, 12'h000}; // RULE_14
        4'h2: if (sendCmdNext && !cmdSnapNext.rd) word = {cmdSnapNext.wdata, 4'h0}; // RULE_14
        ac_link_pkg::LAST_SLOT: if (sendModemNext) word = modemSnapNext; // RULE_08
        default: word = 20'h00000;
      endcase
      sdoNext  = word[bitIdxNext];
      syncNext = slotNext == 4'h0;
    end
    // Software writes land after the frame-start clear, so a set wins
    if (wrEn && hit(paddr, ac_link_pkg::CMD_OFS)) begin
      cmdNext = ac_link_pkg::cmd_t'(pwdata[24:0]);
      if (pwdata[ac_link_pkg::CMD_ENA_BIT] && pwdata[ac_link_pkg::CMD_RD_BIT]) begin
        rdValidNext = 1'b0; // RULE_03
      end
    end
    if (wrEn && hit(paddr, ac_link_pkg::MCTL_OFS)) begin
      modemEnaNext = pwdata[ac_link_pkg::MCTL_ENA_BIT];
      modemCtlNext = pwdata[19:0];
    end
    if (wrEn && hit(paddr, ac_link_pkg::IST_OFS)) istatNext = istat_reg & ~pwdata[1:0];
    if (wrEn && hit(paddr, ac_link_pkg::IMSK_OFS)) imaskNext = pwdata[1:0];
    // Incoming side: sample on the falling edge, act on the last bit of slots 0, 1, 2 and 12
    if (fall) begin
      inShiftNext = w;
      if (bitIdx_reg == 5'h00) begin
        case (slot_reg)
          4'h0: begin
            codecReadyNext = w[ac_link_pkg::TAG_READY]; // RULE_01
            inTagNext      = w[15:0];
          end
          4'h1: if (inTag_reg[ac_link_pkg::TAG_CMD]) echoNext = w[18:12]; // RULE_15
          4'h2: if (inTag_reg[ac_link_pkg::TAG_DATA]
                    && rdState_reg == ac_link_pkg::RD_WAIT) begin
            readDataNext = w[19:4]; // RULE_05
            echoIdxNext  = echo_reg; // RULE_04
            rdValidNext  = 1'b1; // RULE_03
            rdStateNext  = ac_link_pkg::RD_IDLE;
            irqSet[ac_link_pkg::IRQ_READ] = 1'b1;
          end
          ac_link_pkg::LAST_SLOT: if (inTag_reg[ac_link_pkg::TAG_MODEM]) begin
            modemStatNext = w; // RULE_09
            irqSet[ac_link_pkg::IRQ_MODEM] = 1'b1; // RULE_10
          end
          default: ;
        endcase
      end
    end
    istatNext = istatNext | irqSet;
    irqNext   = |(istatNext & imaskNext);
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bclkMeta_reg   <= 1'b0;
      bclkSync_reg   <= 1'b0;
      bclkPrev_reg   <= 1'b0;
      sdinMeta_reg   <= 1'b0;
      sdinSync_reg   <= 1'b0;
      slot_reg       <= ac_link_pkg::LAST_SLOT;
      bitIdx_reg     <= 5'h00;
      inShift_reg    <= 20'h00000;
      inTag_reg      <= 16'h0000;
      sync_reg       <= 1'b0;
      sdo_reg        <= 1'b0;
      cmd_reg        <= ac_link_pkg::REG_RST[24:0];
      cmdSnap_reg    <= ac_link_pkg::REG_RST[24:0];
      sendCmd_reg    <= 1'b0;
      modemEna_reg   <= 1'b0;
      modemCtl_reg   <= ac_link_pkg::REG_RST[19:0];
      modemSnap_reg  <= 20'h00000;
      sendModem_reg  <= 1'b0;
      modemStat_reg  <= ac_link_pkg::REG_RST[19:0];
      codecReady_reg <= 1'b0;
      rdValid_reg    <= 1'b0;
      echo_reg       <= 7'h00;
      echoIdx_reg    <= 7'h00;
      readData_reg   <= 16'h0000;
      rdState_reg    <= ac_link_pkg::RD_IDLE;
      istat_reg      <= 2'h0;
      imask_reg      <= 2'h0;
      irq_reg        <= 1'b0;
      prdata_reg     <= 32'h00000000;
      pready_reg     <= 1'b0;
      pslverr_reg    <= 1'b0;
      rxPurge_reg    <= 1'b0;
      txPurge_reg    <= 1'b0;
    end else begin
      bclkMeta_reg   <= bitClk;
      bclkSync_reg   <= bclkMeta_reg;
      bclkPrev_reg   <= bclkSync_reg;
      sdinMeta_reg   <= sdataIn;
      sdinSync_reg   <= sdinMeta_reg;
      slot_reg       <= slotNext;
      bitIdx_reg     <= bitIdxNext;
      inShift_reg    <= inShiftNext;
      inTag_reg      <= inTagNext;
      sync_reg       <= syncNext;
      sdo_reg        <= sdoNext;
      cmd_reg        <= cmdNext;
      cmdSnap_reg    <= cmdSnapNext;
      sendCmd_reg    <= sendCmdNext;
      modemEna_reg   <= modemEnaNext;
      modemCtl_reg   <= modemCtlNext;
      modemSnap_reg  <= modemSnapNext;
      sendModem_reg  <= sendModemNext;
      modemStat_reg  <= modemStatNext;
      codecReady_reg <= codecReadyNext;
      rdValid_reg    <= rdValidNext;
      echo_reg       <= echoNext;
      echoIdx_reg    <= echoIdxNext;
      readData_reg   <= readDataNext;
      rdState_reg    <= rdStateNext;
      istat_reg      <= istatNext;
      imask_reg      <= imaskNext;
      irq_reg        <= irqNext;
      prdata_reg     <= prdataNext;
      pready_reg     <= preadyNext;
      pslverr_reg    <= pslverrNext;
      rxPurge_reg    <= rxPurgeNext;
      txPurge_reg    <= txPurgeNext;
    end
  end
  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign irq      = irq_reg;
  assign syncOut  = sync_reg;
  assign sdataOut = sdo_reg;
  assign rxPurge  = rxPurge_reg;
  assign txPurge  = txPurge_reg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ready_mirror_a: assert property ( // RULE_01
    fall && slot_reg == 4'h0 && bitIdx_reg == 5'h00
    |=> codecReady_reg == $past(inShift_reg[ac_link_pkg::TAG_READY - 1]))
    else $error("codec ready flag does not follow slot 0 tag");
  valid_clear_a: assert property ( // RULE_03
    wrEn && hit(paddr, ac_link_pkg::CMD_OFS) && pwdata[24] && pwdata[7] && !fall
    |=> !rdValid_reg)
    else $error("read request did not clear readback valid");
  index_load_a: assert property ( // RULE_04
    $rose(rdValid_reg) |-> echoIdx_reg == $past(echo_reg, 1))
    else $error("echoed index not taken from slot 1");
  data_hold_a: assert property ( // RULE_05
    rdState_reg != ac_link_pkg::RD_WAIT |=> $stable(readData_reg))
    else $error("read data changed without a returned read");
  modem_send_a: assert property ( // RULE_06
    frameStart && modemEna_reg && !(wrEn && hit(paddr, ac_link_pkg::MCTL_OFS))
    |=> sendModem_reg && !modemEna_reg)
    else $error("slot 12 request not taken and cleared at frame start");
  slot12_bits_a: assert property ( // RULE_08
    sendModem_reg && slot_reg == ac_link_pkg::LAST_SLOT
    |-> sdo_reg == modemSnap_reg[bitIdx_reg])
    else $error("slot 12 carries wrong payload bit");
  modem_irq_a: assert property ( // RULE_10
    fall && slot_reg == ac_link_pkg::LAST_SLOT && bitIdx_reg == 5'h00
    && inTag_reg[ac_link_pkg::TAG_MODEM]
    |=> modemStat_reg == $past(w) && istat_reg[ac_link_pkg::IRQ_MODEM]
    ##1 irq == |(istat_reg & imask_reg))
    else $error("modem status update not captured or not flagged");
  rx_purge_a: assert property ( // RULE_11
    wrEn && hit(paddr, ac_link_pkg::FIFO_OFS) && pwdata[31] |=> rxPurge ##1 !rxPurge)
    else $error("receive purge pulse missing");
  tx_purge_a: assert property ( // RULE_12
    wrEn && hit(paddr, ac_link_pkg::FIFO_OFS) && pwdata[30] |=> txPurge ##1 !txPurge)
    else $error("transmit purge pulse missing");
  rx_level_a: assert property ( // RULE_13
    preadyNext && hit(paddr, ac_link_pkg::FIFO_OFS)
    |=> prdata[15:8] == $past(rxLevel) && pready)
    else $error("receive level not reported");
  cmd_send_a: assert property ( // RULE_14
    frameStart && cmd_reg.ena |=> sendCmd_reg && sync_reg)
    else $error("command not scheduled in next frame");
endmodule

// ===== ac_codec_model.sv
// Behavioural codec model on the far side of the AC-link
`timescale 1ns/1ps
module ac_codec_model (
  input  wire logic        run,       // Let the bit clock run
  input  wire logic        syncOut,   // Frame sync from the block
  input  wire logic        sdataOut,  // Serial data from the block
  input  wire logic [15:0] inTag,     // Tag to send
  input  wire logic [19:0] inSlot1,   // Slot 1 to send
  input  wire logic [19:0] inSlot2,   // Slot 2 to send
  input  wire logic [19:0] inSlot12,  // Slot 12 to send
  output logic             bitClk,    // Link bit clock
  output logic             sdataIn,   // Serial data to the block
  output logic      [15:0] outTag,    // Last received tag
  output logic      [19:0] outSlot1,  // Last received slot 1
  output logic      [19:0] outSlot2,  // Last received slot 2
  output logic      [19:0] outSlot12, // Last received slot 12
  output logic      [15:0] frameNo,   // Frames received
  output logic      [7:0]  syncErr    // Bits with a wrong sync level
);
  logic [255:0] txFrame;
  logic [255:0] rxFrame;
  int           idx;

  initial begin
    bitClk = 1'b0;
    sdataIn = 1'b0;
    outTag = 16'h0;
    outSlot1 = 20'h0;
    outSlot2 = 20'h0;
    outSlot12 = 20'h0;
    frameNo = 16'h0;
    syncErr = 8'h0;
    txFrame = 256'h0;
    rxFrame = 256'h0;
    idx = 255;
    #137;
    forever begin
      #200;
      if (run || bitClk) bitClk = ~bitClk;
      else sdataIn = ~sdataIn; // Idle data keeps moving so a stale bit is never trusted
    end
  end

  // Sample at the next rise: the block's bit stands until then
  always @(posedge bitClk) begin
    rxFrame[255 - idx] = sdataOut;
    if (syncOut !== (idx < 16)) syncErr = syncErr + 8'h01;
    if (idx == 255) begin
      outTag = rxFrame[255:240];
      outSlot1 = rxFrame[239:220];
      outSlot2 = rxFrame[219:200];
      outSlot12 = rxFrame[19:0];
      frameNo = frameNo + 16'h0001;
      txFrame = {inTag, inSlot1, inSlot2, 180'h0, inSlot12};
    end
    idx = (idx + 1) % 256;
    sdataIn = txFrame[255 - idx];
  end
endmodule

// ===== tb_ac_link_status_modem_fifo.sv
// Self-checking bench for the AC-link status, modem slot and FIFO status block
`timescale 1ns/1ps
module tb_ac_link_status_modem_fifo;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        bitClk;
  logic        sdataIn;
  logic        syncOut;
  logic        sdataOut;
  logic [7:0]  rxLevel = 8'h5A;
  logic [7:0]  txLevel = 8'h3C;
  logic        rxPurge;
  logic        txPurge;
  logic        run = 1'b0;
  logic [15:0] inTag = 16'h8000;
  logic [19:0] inSlot1 = 20'h0;
  logic [19:0] inSlot2 = 20'h0;
  logic [19:0] inSlot12 = 20'h0;
  logic [15:0] outTag;
  logic [19:0] outSlot1;
  logic [19:0] outSlot2;
  logic [19:0] outSlot12;
  logic [15:0] frameNo;
  logic [7:0]  syncErr;
  logic [31:0] rd;
  logic        err;
  int          failCount = 0;
  int          totalChecks = 0;
  int          rxPulses = 0;
  int          txPulses = 0;

  ac_link_status_modem_fifo i_dut (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .bitClk(bitClk), .sdataIn(sdataIn), .syncOut(syncOut),
    .sdataOut(sdataOut), .rxLevel(rxLevel), .txLevel(txLevel), .rxPurge(rxPurge),
    .txPurge(txPurge));

  ac_codec_model i_codec (.run(run), .syncOut(syncOut), .sdataOut(sdataOut), .inTag(inTag),
    .inSlot1(inSlot1), .inSlot2(inSlot2), .inSlot12(inSlot12), .bitClk(bitClk),
    .sdataIn(sdataIn), .outTag(outTag), .outSlot1(outSlot1), .outSlot2(outSlot2),
    .outSlot12(outSlot12), .frameNo(frameNo), .syncErr(syncErr));

  always #25 mclk = ~mclk;

  always @(posedge mclk) begin
    if (rxPurge === 1'b1) rxPulses <= rxPulses + 1;
    if (txPurge === 1'b1) txPulses <= txPulses + 1;
  end

  task automatic closeOut();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (n == 20) begin
      failCount++;
      closeOut();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  // Ends a few bits into a frame so a following write misses that frame's start
  task automatic waitFrames(input int f);
    logic [15:0] target;
    int          n;
    target = frameNo + f[15:0];
    n = 0;
    while (frameNo !== target && n < 3000 * f) begin
      @(posedge mclk);
      n++;
    end
    if (frameNo !== target) begin
      failCount++;
      closeOut();
    end
    repeat (40) @(posedge mclk);
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rdChk("readback reset", 12'h024, 32'h0);
    rdChk("modem ctl reset", 12'h028, 32'h0);
    rdChk("modem stat reset", 12'h02C, 32'h0);
    rdChk("fifo levels", 12'h030, 32'h00005A3C);
    xfer(1'b0, 12'h03C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    run <= 1'b1;
    waitFrames(2);
    rdChk("codec ready", 12'h024, 32'h01000000);
    inTag <= 16'h0000;
    waitFrames(2);
    rdChk("codec not ready", 12'h024, 32'h0);
    inTag <= 16'h8000;
    waitFrames(2);
    rdChk("codec ready again", 12'h024, 32'h01000000);
    xfer(1'b1, 12'h030, 32'h80000000);
    repeat (3) @(posedge mclk);
    chk("rx purge pulses", 32'h1, rxPulses);
    chk("tx purge idle", 32'h0, txPulses);
    xfer(1'b1, 12'h030, 32'h40000000);
    rxLevel <= 8'hFF;
    repeat (3) @(posedge mclk);
    chk("tx purge pulses", 32'h1, txPulses);
    chk("rx purge once", 32'h1, rxPulses);
    rdChk("purge self clear", 12'h030, 32'h0000FF3C);
    xfer(1'b1, 12'h044, 32'h3);
    xfer(1'b1, 12'h020, 32'h010000AA);
    waitFrames(2);
    chk("cmd tag", 32'hC000, {16'h0, outTag & 16'hE008});
    chk("cmd slot1", 32'hAA, {24'h0, outSlot1[19:12]});
    rdChk("cmd self clear", 12'h020, 32'h000000AA);
    inTag <= 16'hE000;
    inSlot1 <= 20'h2A000;
    inSlot2 <= 20'hBEEF0;
    waitFrames(2);
    inTag <= 16'h8000;
    rdChk("readback", 12'h024, 32'h01AABEEF);
    chk("read irq", 32'h1, {31'h0, irq});
    rdChk("read irq status", 12'h040, 32'h1);
    xfer(1'b1, 12'h040, 32'h1);
    repeat (2) @(posedge mclk);
    chk("read irq cleared", 32'h0, {31'h0, irq});
    xfer(1'b1, 12'h020, 32'h01123411);
    waitFrames(2);
    chk("wr cmd tag", 32'hE000, {16'h0, outTag & 16'hE008});
    chk("wr cmd slot1", 32'h11, {24'h0, outSlot1[19:12]});
    chk("wr cmd slot2", 32'h1234, {16'h0, outSlot2[19:4]});
    rdChk("valid kept on write", 12'h024, 32'h01AABEEF);
    xfer(1'b1, 12'h020, 32'h01000085);
    rdChk("valid cleared", 12'h024, 32'h012ABEEF);
    xfer(1'b1, 12'h028, 32'h00112345);
    waitFrames(2);
    chk("modem out tag", 32'h8008, {16'h0, outTag & 16'h8008});
    chk("modem out slot", 32'h12345, {12'h0, outSlot12});
    rdChk("modem self clear", 12'h028, 32'h00012345);
    waitFrames(1);
    chk("modem sent once", 32'h0, {16'h0, outTag & 16'h0008});
    inTag <= 16'h8008;
    inSlot12 <= 20'hA5A5A;
    waitFrames(2);
    rdChk("modem status", 12'h02C, 32'h000A5A5A);
    chk("modem irq", 32'h1, {31'h0, irq});
    xfer(1'b1, 12'h040, 32'h2);
    rdChk("modem irq cleared", 12'h040, 32'h0);
    waitFrames(1);
    rdChk("modem irq again", 12'h040, 32'h2);
    xfer(1'b1, 12'h044, 32'h0);
    repeat (2) @(posedge mclk);
    chk("masked irq", 32'h0, {31'h0, irq});
    chk("sync framing", 32'h0, {24'h0, syncErr});
    closeOut();
  end
endmodule
